/* File: verilog/balance_switch_pulser.sv */
// balance switch pulser: 18 switch pins driven from 4-bit settings
// assumes an AXI4-Lite master on core_clk and synchronous active high reset
//
// Contract
// - hold a 4-bit setting per pin, 18 pins
// - pulses repeat every 155 us
// - each pulse lasts 77.6 us
// - start only on correct command check code
// - poll output low until sequence done
// - ignore start and writes while pulsing
// - completion visible through poll status
// - bad data check clears all settings
// - discharge enable bit forces pin low
// - clear command zeroes settings, stops engine
// - mute disables outputs, registers kept
// - mute and unmute carry no data, fast
// - mute state readable as status bit
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "balance_switch_pulser_defs.svh"

module balance_switch_pulser #(
    parameter int PINS          = 18,
    parameter int PERIOD_CYCLES = `PULSE_PERIOD_CYC,
    parameter int WIDTH_CYCLES  = `PULSE_WIDTH_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [PINS-1:0]        switch_pin
);

    localparam int PW = $clog2(PERIOD_CYCLES);

    // ----------------------------------------------------------------
    // address decode helpers
    // ----------------------------------------------------------------

    // true for every offset the block answers with OKAY
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == `OFS_COMMAND) || (addr == `OFS_STAGE_A_LOW)
                 || (addr == `OFS_STAGE_A_HIGH) || (addr == `OFS_STAGE_B)
                 || (addr == `OFS_DISCHARGE) || (addr == `OFS_STATUS)
                 || (addr == `OFS_LIVE_A_LOW) || (addr == `OFS_LIVE_A_HIGH)
                 || (addr == `OFS_LIVE_B);
    endfunction : is_mapped

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++)
        begin
            old[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction : merge

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]                       aw_addr;
    logic [31:0]                      w_data;
    logic [3:0]                       w_strb;
    logic                             aw_held;
    logic                             w_held;
    logic                             wr_commit;
    logic [31:0]                      stage_a_low;
    logic [15:0]                      stage_a_high;
    logic [23:0]                      stage_b;
    logic [PINS-1:0]                  discharge;
    logic [4*PINS-1:0]                settings;
    logic                             mute;
    balance_switch_pulser_pkg::pulse_state_t state;
    logic [PW-1:0]                    phase;
    logic [2:0]                       pulse_idx;
    logic [2:0]                       longest;
    logic [31:0]                      read_word;
    logic [PINS-1:0]                  next_pin;
    logic [PINS-1:0]                  top_code;
    logic                             cmd_hit;
    logic                             cmd_ok;
    logic                             data_ok;
    logic [2:0]                       opcode;
    logic                             busy;

    assign busy      = (state == balance_switch_pulser_pkg::PULSE_RUN);
    assign wr_commit = aw_held && w_held && !s_axi_bvalid;
    assign cmd_hit   = wr_commit && (aw_addr == `OFS_COMMAND) && w_strb[0];
    assign opcode    = w_data[`CMD_OPCODE_MSB:0];
    assign cmd_ok    = w_data[`CMD_CHECK_OK_BIT];
    assign data_ok   = w_data[`DATA_CHECK_OK_BIT];

    // ----------------------------------------------------------------
    // axi4-lite write channels, address and data taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end
        else
        begin
            if (wr_commit)
                aw_held <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_wready <= 1'b0;
            w_held       <= 1'b0;
            w_data       <= `RST_WORD;
            w_strb       <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end
        else
        begin
            if (wr_commit)
                w_held <= 1'b0;
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_commit)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // software registers: staging words and discharge enables
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage_a_low  <= `RST_WORD;
            stage_a_high <= 16'h0000;
            stage_b      <= 24'h00_0000;
            discharge    <= '0;
        end
        else if (wr_commit)
        begin
            if (aw_addr == `OFS_STAGE_A_LOW)
                stage_a_low <= merge(stage_a_low, w_data, w_strb);
            if (aw_addr == `OFS_STAGE_A_HIGH)
                stage_a_high <= 16'(merge({16'h0000, stage_a_high}, w_data, w_strb));
            if (aw_addr == `OFS_STAGE_B)
                stage_b <= 24'(merge({8'h00, stage_b}, w_data, w_strb));
            if (aw_addr == `OFS_DISCHARGE)
                discharge <= PINS'(merge({{(32-PINS){1'b0}}, discharge}, w_data, w_strb));
        end
    end

    // ----------------------------------------------------------------
    // live switch settings, committed by command
    // ----------------------------------------------------------------
    // settings update
    always_ff @(posedge core_clk)
    begin
        if (reset)
            settings <= '0;
        else if (cmd_hit && cmd_ok)
        begin
            if (opcode == balance_switch_pulser_pkg::CMD_CLEAR)
                settings <= '0;
            else if (!busy && (opcode == balance_switch_pulser_pkg::CMD_WRITE_A))
                settings[47:0] <= data_ok ? {stage_a_high, stage_a_low} : 48'h0;
            else if (!busy && (opcode == balance_switch_pulser_pkg::CMD_WRITE_B))
            begin
                if (data_ok)
                    settings[71:48] <= stage_b;
                else
                    settings <= '0;
            end
            if (!busy && !data_ok && (opcode == balance_switch_pulser_pkg::CMD_WRITE_A))
                settings[71:48] <= 24'h00_0000;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            mute <= 1'b0;
        else if (cmd_hit && cmd_ok && (opcode == balance_switch_pulser_pkg::CMD_MUTE))
            mute <= 1'b1;
        else if (cmd_hit && cmd_ok && (opcode == balance_switch_pulser_pkg::CMD_UNMUTE))
            mute <= 1'b0;
    end

    // ----------------------------------------------------------------
    // pulse engine
    // ----------------------------------------------------------------
    // longest requested train among pulsing codes
    always_comb
    begin
        longest = 3'h0;
        for (int p = 0; p < PINS; p++)
        begin
            if (!settings[4*p+3] && (settings[4*p +: 3] > longest))
                longest = settings[4*p +: 3];
        end
    end

    // settings change while running only on clear, which also stops the engine, so longest stays stable
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state     <= balance_switch_pulser_pkg::PULSE_IDLE;
            phase     <= '0;
            pulse_idx <= 3'h0;
        end
        else
        begin
            case (state)
                balance_switch_pulser_pkg::PULSE_IDLE:
                begin
                    phase     <= '0;
                    pulse_idx <= 3'h0;
                    if (cmd_hit && cmd_ok && (longest != 3'h0)
                        && (opcode == balance_switch_pulser_pkg::CMD_START))
                        state <= balance_switch_pulser_pkg::PULSE_RUN;
                end
                balance_switch_pulser_pkg::PULSE_RUN:
                begin
                    if (cmd_hit && cmd_ok && (opcode == balance_switch_pulser_pkg::CMD_CLEAR))
                        state <= balance_switch_pulser_pkg::PULSE_IDLE;
                    else if (phase == PW'(PERIOD_CYCLES - 1))
                    begin
                        phase     <= '0;
                        pulse_idx <= pulse_idx + 3'h1;
                        if (pulse_idx + 3'h1 == longest)
                            state <= balance_switch_pulser_pkg::PULSE_IDLE;
                    end
                    else
                        phase <= phase + PW'(1);
                end
                default: state <= balance_switch_pulser_pkg::PULSE_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive, one generate slice per pin
    // ----------------------------------------------------------------
    generate
        for (genvar p = 0; p < PINS; p++)
        begin : g_pin
            // top bit of each code, shared by pin drive checks
            assign top_code[p] = settings[4*p+3];

            always_comb
            begin
                if (mute || discharge[p] || settings[4*p+3])
                    next_pin[p] = 1'b0;
                else if (busy && (pulse_idx < settings[4*p +: 3])
                         && (phase < PW'(WIDTH_CYCLES)))
                    next_pin[p] = 1'b0;
                else
                    next_pin[p] = 1'b1;
            end
        end
    endgenerate

    // registered pins
    always_ff @(posedge core_clk)
    begin
        if (reset)
            switch_pin <= '0;
        else
            switch_pin <= next_pin;
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        case (s_axi_araddr)
            `OFS_STAGE_A_LOW:  read_word = stage_a_low;
            `OFS_STAGE_A_HIGH: read_word = {16'h0000, stage_a_high};
            `OFS_STAGE_B:      read_word = {8'h00, stage_b};
            `OFS_DISCHARGE:    read_word = {{(32-PINS){1'b0}}, discharge};
            `OFS_STATUS:       read_word = {29'h0, mute, !busy, busy};
            `OFS_LIVE_A_LOW:   read_word = settings[31:0];
            `OFS_LIVE_A_HIGH:  read_word = {16'h0000, settings[47:32]};
            `OFS_LIVE_B:       read_word = {8'h00, settings[71:48]};
            default:           read_word = `RST_WORD;
        endcase
    end

    // one read at a time, answer the cycle after the address is taken
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `RST_WORD;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_word;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_START_GATE: assert property ($rose(busy) |-> $past(cmd_hit && cmd_ok
        && opcode == balance_switch_pulser_pkg::CMD_START)) else $error("start without good check");
    AST_PERIOD_WRAP: assert property (busy && phase == PW'(PERIOD_CYCLES - 1)
        && !cmd_hit |=> phase == '0 || !busy) else $error("period wrap wrong");
    AST_PULSE_WIDTH: assert property (busy && phase == PW'(WIDTH_CYCLES) && !mute
        && discharge == '0 && !cmd_hit |=> switch_pin == ~top_code)
        else $error("pulse width wrong");
    AST_POLL_LOW: assert property (busy |-> read_word[`STAT_POLL_BIT] == 1'b0
        || s_axi_araddr != `OFS_STATUS) else $error("poll high while busy");
    AST_WRITE_IGNORED: assert property (busy && cmd_hit
        && (opcode == balance_switch_pulser_pkg::CMD_WRITE_A
        || opcode == balance_switch_pulser_pkg::CMD_WRITE_B) |=> $stable(settings))
        else $error("write accepted while busy");
    AST_BUSY_ENDS: assert property ($fell(busy) |-> $past(pulse_idx) + 3'h1 == longest
        || $past(cmd_hit)) else $error("sequence ended early");
    AST_BAD_DATA: assert property (!busy && cmd_hit && cmd_ok && !data_ok
        && (opcode == balance_switch_pulser_pkg::CMD_WRITE_A
        || opcode == balance_switch_pulser_pkg::CMD_WRITE_B) |=> settings == '0)
        else $error("bad data did not clear");
    AST_DISCHARGE_LOW: assert property (discharge != '0
        |=> (switch_pin & $past(discharge)) == '0)
        else $error("discharge did not force low");
    AST_CLEAR: assert property (cmd_hit && cmd_ok
        && opcode == balance_switch_pulser_pkg::CMD_CLEAR |=> settings == '0 && !busy)
        else $error("clear incomplete");
    AST_MUTE_FAST: assert property (cmd_hit && cmd_ok
        && opcode == balance_switch_pulser_pkg::CMD_MUTE |=> ##1 switch_pin == '0)
        else $error("mute not applied in two cycles");
    AST_TOP_BIT_LOW: assert property (top_code != '0
        |=> (switch_pin & $past(top_code)) == '0)
        else $error("code with top bit not low");

endmodule : balance_switch_pulser

/* File: verilog/balance_switch_pulser_defs.svh */
// register offsets, field positions, reset values and timing figures
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef BALANCE_SWITCH_PULSER_DEFS_SVH
`define BALANCE_SWITCH_PULSER_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_COMMAND        8'h00
`define OFS_STAGE_A_LOW    8'h04
`define OFS_STAGE_A_HIGH   8'h08
`define OFS_STAGE_B        8'h0c
`define OFS_DISCHARGE      8'h10
`define OFS_STATUS         8'h14
`define OFS_LIVE_A_LOW     8'h18
`define OFS_LIVE_A_HIGH    8'h1c
`define OFS_LIVE_B         8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_OPCODE_MSB     2
`define CMD_CHECK_OK_BIT   8
`define DATA_CHECK_OK_BIT  9
`define STAT_BUSY_BIT      0
`define STAT_POLL_BIT      1
`define STAT_MUTE_BIT      2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SETTING        4'h0
`define RST_WORD           32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define PULSE_PERIOD_NS    155000
`define PULSE_WIDTH_NS     77600
`define PULSE_PERIOD_CYC   (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
`define PULSE_WIDTH_CYC    (`PULSE_WIDTH_NS / `CLK_PERIOD_NS)

`endif

/* File: verilog/balance_switch_pulser_pkg.sv */
// types shared by the balance switch pulser
// assumes nothing beyond a SystemVerilog compiler
package balance_switch_pulser_pkg;

    // pulse engine state, one bit so trivially gray
    typedef enum logic
    {
        PULSE_IDLE = 1'b0,
        PULSE_RUN  = 1'b1
    } pulse_state_t;

    // command opcodes written to the command register
    typedef enum logic [2:0]
    {
        CMD_NONE        = 3'h0,
        CMD_WRITE_A     = 3'h1,
        CMD_WRITE_B     = 3'h2,
        CMD_START       = 3'h3,
        CMD_CLEAR       = 3'h4,
        CMD_MUTE        = 3'h5,
        CMD_UNMUTE      = 3'h6
    } cmd_op_t;

endpackage : balance_switch_pulser_pkg

/* File: testbench/switch_pin_listener.sv */
// far side of the switch pins: counts low pulses, their width and spacing
// assumes the pins idle high and the listener shares the block clock
`timescale 1ns/100ps

module switch_pin_listener #(
    parameter int PINS = 18
) (
    input  wire logic            core_clk,
    input  wire logic            clear,
    input  wire logic [PINS-1:0] switch_pin,
    output int                   pulses [PINS],
    output int                   low_len [PINS],
    output int                   gap [PINS]
);
    logic [PINS-1:0] prev = '0;
    int              run [PINS];
    int              since [PINS];

    // a pulse is a high-to-low step; width is the low run, gap is fall to fall
    always @(posedge core_clk)
    begin
        prev <= switch_pin;
        for (int i = 0; i < PINS; i++)
        begin
            run[i] <= switch_pin[i] ? 0 : run[i] + 1;
            since[i] <= (prev[i] & ~switch_pin[i]) ? 1 : since[i] + 1;
            if (clear)
                pulses[i] <= 0;
            else if (prev[i] & ~switch_pin[i])
                pulses[i] <= pulses[i] + 1;
            if (prev[i] & ~switch_pin[i])
                gap[i] <= since[i];
            if (~prev[i] & switch_pin[i])
                low_len[i] <= run[i];
        end
    end
endmodule : switch_pin_listener

/* File: testbench/balance_switch_pulser_tb_top.sv */
// self-checking bench: register bus master plus pin listener
// assumes short pulse timing parameters, 20 and 10 cycles
`timescale 1ns/100ps
`include "balance_switch_pulser_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end

module balance_switch_pulser_tb_top;
    localparam int P = 20;
    localparam int W = 10;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, sa_lo, sa_hi, sb;
    logic [17:0] switch_pin, steady;
    logic        mon_clear = 1'b0;
    int          pulses [18], low_len [18], gap [18];
    int          num_errors = 0;
    int          checks_done = 0;
    logic [33:0] rd_q [$], rexp;
    logic [1:0]  wr_q [$], bexp;
    logic [3:0]  code [18];
    int          seed;

    balance_switch_pulser #(.PINS(18), .PERIOD_CYCLES(P), .WIDTH_CYCLES(W)) DUT (
        .core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_pin);

    switch_pin_listener #(.PINS(18)) listener (.core_clk, .clear(mon_clear),
        .switch_pin, .pulses, .low_len, .gap);

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------
    // bus master tasks, answers checked by the watcher
    // ------------------------------------------------
    // only the watchdog ends a stuck wait, and it counts it as a mismatch
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr_q.push_back(2'b00);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        @(posedge core_clk);
        rd_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // command word: opcode, command check flag, data check flag
    task automatic cmd(input logic [2:0] op, input logic cok, input logic dok);
        wr(`OFS_COMMAND, {22'h0, dok, cok, 5'h0, op});
    endtask : cmd

    // let the pin lag settle before looking
    task automatic pins(input logic [17:0] e);
        repeat (3) @(posedge core_clk);
        #1 `CHK(switch_pin, e)
    endtask : pins

    task wrap_up;
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // watcher: oldest note against each answer
    always @(posedge core_clk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            rexp = rd_q.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, rexp)
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            bexp = wr_q.pop_front();
            `CHK(s_axi_bresp, bexp)
        end
    end

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        seed = $urandom(67022);
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        pins(18'h3ffff);
        rd(`OFS_STATUS, 2'b00, 32'h2);
        rd(8'h24, 2'b10, 32'h0);
        // codes 0..7 on pins 0..7, top bit on pin 8, random elsewhere
        for (int i = 0; i < 18; i++) code[i] = (i < 8) ? 4'(i) : 4'($urandom_range(7, 0));
        code[8] = 4'hc;
        sa_hi = '0;
        sb = '0;
        for (int i = 0; i < 18; i++) steady[i] = ~code[i][3];
        for (int i = 0; i < 8; i++) sa_lo[4*i +: 4] = code[i];
        for (int i = 0; i < 4; i++) sa_hi[4*i +: 4] = code[8+i];
        for (int i = 0; i < 6; i++) sb[4*i +: 4] = code[12+i];
        wr(`OFS_STAGE_A_LOW, sa_lo);
        wr(`OFS_STAGE_A_HIGH, sa_hi);
        wr(`OFS_STAGE_B, sb);
        cmd(3'h1, 1'b1, 1'b1);
        cmd(3'h2, 1'b1, 1'b1);
        rd(`OFS_LIVE_A_HIGH, 2'b00, sa_hi);
        rd(`OFS_LIVE_B, 2'b00, sb);
        pins(steady);
        cmd(3'h3, 1'b0, 1'b1);
        rd(`OFS_STATUS, 2'b00, 32'h2);
        mon_clear <= 1'b1;
        @(posedge core_clk);
        mon_clear <= 1'b0;
        // start, then try to disturb the running train
        cmd(3'h3, 1'b1, 1'b1);
        rd(`OFS_STATUS, 2'b00, 32'h1);
        wr(`OFS_STAGE_A_LOW, 32'h0);
        cmd(3'h1, 1'b1, 1'b1);
        cmd(3'h3, 1'b1, 1'b1);
        repeat (90) @(posedge core_clk);
        rd(`OFS_STATUS, 2'b00, 32'h1);
        repeat (40) @(posedge core_clk);
        rd(`OFS_STATUS, 2'b00, 32'h2);
        rd(`OFS_LIVE_A_LOW, 2'b00, sa_lo);
        for (int i = 0; i < 18; i++)
        begin
            if (!code[i][3]) `CHK(pulses[i], int'(code[i]))
            if (!code[i][3] && code[i] > 0) `CHK(low_len[i], W)
            if (!code[i][3] && code[i] > 1) `CHK(gap[i], P)
        end
        pins(steady);
        // mute keeps registers, unmute restores
        cmd(3'h5, 1'b1, 1'b1);
        pins(18'h0);
        rd(`OFS_STATUS, 2'b00, 32'h6);
        rd(`OFS_LIVE_A_LOW, 2'b00, sa_lo);
        cmd(3'h6, 1'b1, 1'b1);
        pins(steady);
        wr(`OFS_DISCHARGE, 32'h4);
        pins(steady & ~18'h4);
        wr(`OFS_DISCHARGE, 32'h0);
        // clear in the middle of a train
        cmd(3'h3, 1'b1, 1'b1);
        repeat (30) @(posedge core_clk);
        cmd(3'h4, 1'b1, 1'b1);
        rd(`OFS_STATUS, 2'b00, 32'h2);
        rd(`OFS_LIVE_A_LOW, 2'b00, 32'h0);
        pins(18'h3ffff);
        // good load, then a bad data check on group B
        wr(`OFS_STAGE_A_LOW, sa_lo);
        cmd(3'h1, 1'b1, 1'b1);
        cmd(3'h2, 1'b1, 1'b1);
        cmd(3'h2, 1'b1, 1'b0);
        rd(`OFS_LIVE_A_LOW, 2'b00, 32'h0);
        rd(`OFS_LIVE_B, 2'b00, 32'h0);
        repeat (3) @(posedge core_clk);
        wrap_up();
    end
endmodule : balance_switch_pulser_tb_top
